// ### ccu_pkg.sv
// Constants, register map and carrier types of the clock calibration unit.
// Assumes an APB slave with 32-bit data and one aligned word per register.
// Contract
// RULE_01: Two timers: duration on the selected slow clock, calibration on the main clock.
// RULE_02: Duration timer is 16 bits wide, calibration timer 24 bits wide.
// RULE_03: Setting start loads duration from reload and clears calibration to zero.
// RULE_04: Duration timer reaching zero makes hardware clear the start bit.
// RULE_05: At the end the final calibration count is stored in the result register.
// RULE_06: Writing start zero during a measurement aborts it at once.
// RULE_07: Software zero coinciding with terminal count loses; measurement completes, done set.
// RULE_08: Writing start one while a measurement runs is ignored.
// RULE_09: While start is zero both timer clocks are gated off.
// RULE_10: Three clock domains; every crossing between them is synchronised. Code: reload_reg and select bit reach the slow domain unsynchronised.
// RULE_11: After reset start reads zero, calibration stopped.
// RULE_12: Control bits 7, 6, 5 and 3 are written zero; reads are undefined.
// RULE_13: Control register gives start, stop, interrupt enable and end flag.
// RULE_14: Done flag set by hardware only; written zero clears, one has no effect.
// RULE_15: Interrupt requested when done and enable are one; flag set regardless.
// RULE_16: Slow clock select zero picks sub oscillator, one picks RC oscillator.
// RULE_17: A reload value of zero makes the measurement last 65536 slow periods.
// RULE_18: The start request passes a synchroniser into the slow domain first.

package ccu_pkg;

  // Bus and timer widths.
  localparam int CCU_ADDR_W = 8;
  localparam int CCU_DATA_W = 32;
  localparam int CCU_DUR_W = 16;
  localparam int CCU_CAL_W = 24;

  // Register byte offsets.
  localparam logic [CCU_ADDR_W-1:0] CCU_OFF_CTRL = 8'h00;
  localparam logic [CCU_ADDR_W-1:0] CCU_OFF_RELOAD = 8'h04;
  localparam logic [CCU_ADDR_W-1:0] CCU_OFF_COUNT = 8'h08;
  localparam logic [CCU_ADDR_W-1:0] CCU_OFF_STATUS = 8'h0C;
  localparam logic [CCU_ADDR_W-1:0] CCU_OFF_CLEAR = 8'h10;
  localparam logic [CCU_ADDR_W-1:0] CCU_OFF_ENABLE = 8'h14;

  // Field positions in the control register.
  localparam int CCU_BIT_START = 4;
  localparam int CCU_BIT_SEL = 2;
  localparam int CCU_BIT_DONE = 1;
  localparam int CCU_BIT_IEN = 0;

  // Field position of the done event in status, clear and enable registers.
  localparam int CCU_BIT_EVT_DONE = 0;

  // Reset values.
  localparam logic [CCU_DUR_W-1:0] CCU_RELOAD_RST = 16'h8000;
  localparam logic [CCU_CAL_W-1:0] CCU_COUNT_RST = 24'h000000;
  localparam logic [CCU_DATA_W-1:0] CCU_RDATA_RST = 32'h00000000;

  // Live control fields, kept together.
  typedef struct packed {
    logic start;
    logic slow_sel;
    logic done;
    logic irq_en;
  } ccu_ctrl_t;

  localparam ccu_ctrl_t CCU_CTRL_RST = '{start: 1'b0, slow_sel: 1'b0, done: 1'b0, irq_en: 1'b0};

  // One APB request as seen by the decoder.
  typedef struct packed {
    logic [CCU_ADDR_W-1:0] addr;
    logic write;
    logic [CCU_DATA_W-1:0] wdata;
  } ccu_apb_req_t;

  // Address compare used by the read mux, the write strobes and the error answer.
  function automatic logic ccu_hit(input logic [CCU_ADDR_W-1:0] addr,
                                   input logic [CCU_ADDR_W-1:0] off);
    ccu_hit = (addr == off);
  endfunction : ccu_hit

endpackage : ccu_pkg

// ### ccu_sync.sv
// Two-stage synchroniser with a domain tick enable and a synchronous clear.
// Assumes the tick marks one edge of the receiving domain's clock.
`timescale 1ns/1ps

module ccu_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Domain tick and clear.
  input wire logic en,
  input wire logic clr,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage, never any other logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else if (clr) begin
      meta_reg <= '0;
      q <= '0;
    end else if (en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : ccu_sync

// ### ccu_top.sv
// Clock calibration unit: APB register file, duration and calibration timers.
// Assumes oscillator inputs are synchronous levels sampled by pclk; each
// oscillator domain is modelled by its rising-edge tick, the peripheral domain by pclk.
`timescale 1ns/1ps

module ccu_top
  import ccu_pkg::*;
#(
  parameter int DUR_W = CCU_DUR_W,
  parameter int CAL_W = CCU_CAL_W
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CCU_ADDR_W-1:0] paddr,
  input wire logic [CCU_DATA_W-1:0] pwdata,
  output logic [CCU_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator clocks sampled as levels.
  input wire logic sub_osc_clock,
  input wire logic rc_osc_clock,
  input wire logic main_osc_clock,
  // Interrupt.
  output logic done_irq
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Register state.
  ccu_ctrl_t ctrl_reg;
  logic [DUR_W-1:0] reload_reg;
  logic [CAL_W-1:0] count_reg;
  logic [CCU_DATA_W-1:0] rdata_reg;
  ccu_apb_req_t req;

  // Oscillator edge detection.
  logic sub_prev_reg;
  logic rc_prev_reg;
  logic main_prev_reg;
  logic slow_edge;
  logic main_edge;
  logic slow_tick;
  logic main_tick;

  // Slow domain.
  logic start_slow;
  logic run_slow_reg;
  logic slow_fin_reg;
  logic slow_go;
  logic slow_end;
  logic [DUR_W-1:0] dur_reg;
  logic [DUR_W-1:0] dur_next;

  // Main domain.
  logic run_main;
  logic run_main_prev_reg;
  logic main_start;
  logic main_stop;
  logic [CAL_W-1:0] cal_reg;
  logic [CAL_W-1:0] held_reg;
  logic done_tgl_reg;

  // Peripheral domain return path.
  logic done_tgl_s;
  logic done_tgl_prev_reg;
  logic done_edge;
  logic done_evt;

  // Bus strobes.
  logic wr_en;
  logic wr_ctrl;
  logic wr_reload;
  logic wr_clear;
  logic wr_enable;
  logic mapped;

  // Collect the request fields.
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  // Writes take effect in the access phase; every register answers with no wait.
  assign wr_en = psel && penable && req.write;
  assign wr_ctrl = wr_en && ccu_hit(req.addr, CCU_OFF_CTRL);
  assign wr_reload = wr_en && ccu_hit(req.addr, CCU_OFF_RELOAD);
  assign wr_clear = wr_en && ccu_hit(req.addr, CCU_OFF_CLEAR);
  assign wr_enable = wr_en && ccu_hit(req.addr, CCU_OFF_ENABLE);

  // Any offset outside the six registers gives an error answer.
  assign mapped = ccu_hit(req.addr, CCU_OFF_CTRL) || ccu_hit(req.addr, CCU_OFF_RELOAD) ||
                  ccu_hit(req.addr, CCU_OFF_COUNT) || ccu_hit(req.addr, CCU_OFF_STATUS) ||
                  ccu_hit(req.addr, CCU_OFF_CLEAR) || ccu_hit(req.addr, CCU_OFF_ENABLE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Oscillator level history, used to find rising edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_prev_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
      main_prev_reg <= 1'b0;
    end else begin
      sub_prev_reg <= sub_osc_clock;
      rc_prev_reg <= rc_osc_clock;
      main_prev_reg <= main_osc_clock;
    end
  end

  // The select bit picks the slow source for the duration timer.
  assign slow_edge = ctrl_reg.slow_sel ? (rc_osc_clock && !rc_prev_reg) // RULE_16
                                       : (sub_osc_clock && !sub_prev_reg);
  assign main_edge = main_osc_clock && !main_prev_reg;

  // Both timer clocks stop while start is low, which also saves their power.
  assign slow_tick = slow_edge && ctrl_reg.start; // RULE_09
  assign main_tick = main_edge && ctrl_reg.start; // RULE_09

  AST_GATE: assert property (!ctrl_reg.start |-> !slow_tick && !main_tick) // RULE_09
    else $error("Timer clock ticked while start was low.");

  // Start request crosses into the slow domain before the duration timer moves.
  ccu_sync #(.W(1)) u_start_sync (
    .clk(pclk),
    .rst_n(presetn),
    .en(slow_tick),
    .clr(!ctrl_reg.start),
    .d(ctrl_reg.start),
    .q(start_slow)
  ); // RULE_18 RULE_10

  // A finished flag stops a second run while start is still waiting to be cleared.
  assign slow_go = slow_tick && start_slow && !run_slow_reg && !slow_fin_reg; // RULE_03
  assign dur_next = dur_reg - DUR_W'(1);
  assign slow_end = slow_tick && run_slow_reg && (dur_next == '0); // RULE_04

  // Duration run state; an abort clears it through the low start bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_slow_reg <= 1'b0;
      slow_fin_reg <= 1'b0;
    end else if (!ctrl_reg.start) begin
      run_slow_reg <= 1'b0; // RULE_06
      slow_fin_reg <= 1'b0;
    end else if (slow_go) begin
      run_slow_reg <= 1'b1;
    end else if (slow_end) begin
      run_slow_reg <= 1'b0;
      slow_fin_reg <= 1'b1;
    end
  end

  // Down counter; a zero reload wraps first, so it lasts a full 65536 ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dur_reg <= '0;
    end else if (slow_go) begin
      dur_reg <= reload_reg; // RULE_03
    end else if (slow_tick && run_slow_reg) begin
      dur_reg <= dur_next; // RULE_01 RULE_02 RULE_17
    end
  end

  AST_LOAD: assert property (slow_go |=> run_slow_reg && dur_reg == $past(reload_reg)) // RULE_03
    else $error("Duration timer did not load the reload value at start.");

  AST_DUR_DEC: assert property (slow_tick && run_slow_reg && !slow_end
                                |=> dur_reg == $past(dur_reg) - DUR_W'(1)) // RULE_17
    else $error("Duration timer did not count down by one.");

  AST_SYNC_START: assert property ($rose(run_slow_reg) |-> $past(ctrl_reg.start, 2)) // RULE_18
    else $error("Duration timer started without a synchronised start.");

  // Run level crosses into the main domain.
  ccu_sync #(.W(1)) u_run_sync (
    .clk(pclk),
    .rst_n(presetn),
    .en(main_tick),
    .clr(!ctrl_reg.start),
    .d(run_slow_reg),
    .q(run_main)
  ); // RULE_10

  // Edges of the run level, seen on main ticks only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_main_prev_reg <= 1'b0;
    end else if (!ctrl_reg.start) begin
      run_main_prev_reg <= 1'b0;
    end else if (main_tick) begin
      run_main_prev_reg <= run_main;
    end
  end

  assign main_start = main_tick && run_main && !run_main_prev_reg;
  assign main_stop = main_tick && !run_main && run_main_prev_reg;

  // Up counter on the main clock; it restarts from zero at each measurement.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg <= '0;
    end else if (main_start) begin
      cal_reg <= '0; // RULE_03
    end else if (main_tick && run_main) begin
      cal_reg <= cal_reg + CAL_W'(1); // RULE_01 RULE_02
    end
  end

  AST_CAL_COUNT: assert property (main_tick && run_main && !main_start
                                  |=> cal_reg == $past(cal_reg) + CAL_W'(1)) // RULE_01
    else $error("Calibration timer did not count up by one.");

  AST_CAL_CLEAR: assert property (main_start |=> cal_reg == '0) // RULE_03
    else $error("Calibration timer did not start from zero.");

  // The final count is held in the main domain and announced by a toggle, so the
  // peripheral side copies a word that no longer moves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_reg <= CCU_COUNT_RST;
      done_tgl_reg <= 1'b0;
    end else if (main_stop) begin
      held_reg <= cal_reg; // RULE_05
      done_tgl_reg <= !done_tgl_reg;
    end
  end

  // Completion toggle crosses back into the peripheral domain.
  ccu_sync #(.W(1)) u_done_sync (
    .clk(pclk),
    .rst_n(presetn),
    .en(1'b1),
    .clr(1'b0),
    .d(done_tgl_reg),
    .q(done_tgl_s)
  ); // RULE_10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_tgl_prev_reg <= 1'b0;
    end else begin
      done_tgl_prev_reg <= done_tgl_s;
    end
  end

  // A completion that lands after an abort is dropped, since start is already low.
  assign done_edge = done_tgl_s ^ done_tgl_prev_reg;
  assign done_evt = done_edge && ctrl_reg.start;

  // Start bit: hardware clear at completion beats any software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.start <= CCU_CTRL_RST.start; // RULE_11
    end else if (done_evt) begin
      ctrl_reg.start <= 1'b0; // RULE_04 RULE_07
    end else if (wr_ctrl) begin
      ctrl_reg.start <= req.wdata[CCU_BIT_START]; // RULE_06 RULE_08 RULE_13
    end
  end

  AST_START_RESET: assert property ($rose(presetn) |-> !ctrl_reg.start) // RULE_11
    else $error("Start bit was not low after reset.");

  AST_IGNORE_ONE: assert property (run_slow_reg && wr_ctrl && req.wdata[CCU_BIT_START]
                                   && !done_evt |=> ctrl_reg.start && dur_reg == $past(dur_reg)
                                   || $past(slow_tick)) // RULE_08
    else $error("Writing one during a measurement disturbed it.");

  AST_ABORT: assert property (run_slow_reg && wr_ctrl && !req.wdata[CCU_BIT_START] && !done_evt
                              |=> !ctrl_reg.start ##1 !run_slow_reg && !run_main) // RULE_06
    else $error("Writing zero did not abort the measurement.");

  // Slow clock select is plain storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.slow_sel <= CCU_CTRL_RST.slow_sel;
    end else if (wr_ctrl) begin
      ctrl_reg.slow_sel <= req.wdata[CCU_BIT_SEL]; // RULE_16
    end
  end

  // Done flag: set wins over either clear path; writing one never sets it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.done <= CCU_CTRL_RST.done;
    end else if (done_evt) begin
      ctrl_reg.done <= 1'b1; // RULE_07 RULE_14 RULE_15
    end else if (wr_ctrl && !req.wdata[CCU_BIT_DONE]) begin
      ctrl_reg.done <= 1'b0; // RULE_14
    end else if (wr_clear && req.wdata[CCU_BIT_EVT_DONE]) begin
      ctrl_reg.done <= 1'b0;
    end
  end

  AST_HW_WINS: assert property (done_evt |=> ctrl_reg.done && !ctrl_reg.start) // RULE_07
    else $error("Completion lost against a software write.");

  AST_DONE_STICKY: assert property (ctrl_reg.done && !wr_ctrl && !wr_clear |=> ctrl_reg.done) // RULE_14
    else $error("Done flag cleared without a software clear.");

  // Interrupt enable, reachable from control and from the enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.irq_en <= CCU_CTRL_RST.irq_en;
    end else if (wr_ctrl) begin
      ctrl_reg.irq_en <= req.wdata[CCU_BIT_IEN]; // RULE_13
    end else if (wr_enable) begin
      ctrl_reg.irq_en <= req.wdata[CCU_BIT_EVT_DONE];
    end
  end

  // Duration reload value; software should change it only while stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= CCU_RELOAD_RST;
    end else if (wr_reload) begin
      reload_reg <= req.wdata[DUR_W-1:0];
    end
  end

  // Result register takes the held count at the moment of completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= CCU_COUNT_RST;
    end else if (done_evt) begin
      count_reg <= held_reg; // RULE_05
    end
  end

  AST_RESULT: assert property (done_evt |=> count_reg == $past(held_reg) ##1
                               $stable(count_reg)) // RULE_05
    else $error("Result register did not capture the final count.");

  // Level interrupt while the flag and its enable are both set.
  assign done_irq = ctrl_reg.done && ctrl_reg.irq_en; // RULE_15

  AST_IRQ: assert property (done_evt && ctrl_reg.irq_en && !wr_ctrl && !wr_enable
                            |=> done_irq) // RULE_15
    else $error("Interrupt not raised on completion with enable set.");

  // Read data is latched in the setup phase so it stands from a flip-flop in the
  // access phase; unused and reserved control bits read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= CCU_RDATA_RST;
    end else if (psel && !penable && !req.write) begin
      rdata_reg <= CCU_RDATA_RST;
      if (ccu_hit(req.addr, CCU_OFF_CTRL)) begin
        rdata_reg[CCU_BIT_START] <= ctrl_reg.start; // RULE_12 RULE_13
        rdata_reg[CCU_BIT_SEL] <= ctrl_reg.slow_sel;
        rdata_reg[CCU_BIT_DONE] <= ctrl_reg.done;
        rdata_reg[CCU_BIT_IEN] <= ctrl_reg.irq_en;
      end else if (ccu_hit(req.addr, CCU_OFF_RELOAD)) begin
        rdata_reg[DUR_W-1:0] <= reload_reg;
      end else if (ccu_hit(req.addr, CCU_OFF_COUNT)) begin
        rdata_reg[CAL_W-1:0] <= count_reg;
      end else if (ccu_hit(req.addr, CCU_OFF_STATUS)) begin
        rdata_reg[CCU_BIT_EVT_DONE] <= ctrl_reg.done;
      end else if (ccu_hit(req.addr, CCU_OFF_ENABLE)) begin
        rdata_reg[CCU_BIT_EVT_DONE] <= ctrl_reg.irq_en;
      end
    end
  end

  assign prdata = rdata_reg;

endmodule : ccu_top

// ### ccu_top_test.sv
// Self-checking testbench of the clock calibration unit, driving APB and three oscillators.
// Assumes the oscillators are levels sampled by pclk and that pready comes high within 49 cycles.
`timescale 1ns/1ps

module ccu_top_test
  import ccu_pkg::*;
;
  // Oscillator periods in pclk cycles, far slower than pclk as the unit expects.
  localparam int SUB_P = 40;
  localparam int RC_P = 24;
  localparam int MAIN_P = 4;
  localparam int LIMIT = 1000;

  // Clock, reset and bus.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [CCU_ADDR_W-1:0] paddr = '0;
  logic [CCU_DATA_W-1:0] pwdata = '0;
  logic [CCU_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic sub_osc_clock = 1'b0;
  logic rc_osc_clock = 1'b0;
  logic main_osc_clock = 1'b0;
  logic done_irq;
  int div_s = 0;
  int div_r = 0;
  int div_m = 0;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] res;
  logic [31:0] last_ctrl;

  ccu_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_osc_clock(sub_osc_clock), .rc_osc_clock(rc_osc_clock),
    .main_osc_clock(main_osc_clock), .done_irq(done_irq)
  );

  // The 50 MHz peripheral clock.
  always #10 pclk = ~pclk;

  // Oscillators run free; the unit itself must gate them while stopped.
  always @(posedge pclk) begin
    div_s <= (div_s == SUB_P - 1) ? 0 : div_s + 1;
    div_r <= (div_r == RC_P - 1) ? 0 : div_r + 1;
    div_m <= (div_m == MAIN_P - 1) ? 0 : div_m + 1;
    sub_osc_clock <= (div_s < SUB_P / 2);
    rc_osc_clock <= (div_r < RC_P / 2);
    main_osc_clock <= (div_m < MAIN_P / 2);
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic hang(input string what);
    fail_count++;
    $display("mismatch %s expected answer seen timeout", what);
    finish_test();
  endtask : hang

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] cw(input logic s, input logic sel, input logic dn,
                                     input logic ie);
    logic [31:0] w;
    w = 32'h00000000;
    w[CCU_BIT_START] = s;
    w[CCU_BIT_SEL] = sel;
    w[CCU_BIT_DONE] = dn;
    w[CCU_BIT_IEN] = ie;
    return w;
  endfunction : cw

  // Starts a measurement, then polls until hardware drops the start bit.
  task automatic meas(input logic sel, input logic ie, input logic [15:0] rl, input int gap);
    int n;
    apb(1'b1, CCU_OFF_RELOAD, {16'h0000, rl}, rd, err);
    apb(1'b1, CCU_OFF_CTRL, cw(1'b1, sel, 1'b0, ie), rd, err);
    apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
    chk("start after write", {31'h0, rd[CCU_BIT_START]}, 32'h1);
    if (gap > 0) begin
      repeat (gap) @(posedge pclk);
      apb(1'b1, CCU_OFF_CTRL, cw(1'b1, sel, 1'b0, ie), rd, err);
    end
    n = 0;
    do begin
      apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
      n++;
    end while (rd[CCU_BIT_START] !== 1'b0 && n < LIMIT);
    if (n >= LIMIT) hang("start clear");
    last_ctrl = rd;
    apb(1'b0, CCU_OFF_COUNT, 32'h00000000, res, err);
  endtask : meas

  // The count must be reload slow periods of main ticks, give or take a few.
  function automatic logic [31:0] in_range(input logic [31:0] r, input int rl, input int per);
    int e;
    e = rl * per / MAIN_P;
    return {31'h0, (int'(r) >= e - 3) && (int'(r) <= e + 3)};
  endfunction : in_range

  task automatic t_reset();
    apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
    chk("control after reset", rd & 32'h00000017, 32'h00000000);
    apb(1'b0, CCU_OFF_RELOAD, 32'h00000000, rd, err);
    chk("reload after reset", rd, {16'h0000, CCU_RELOAD_RST});
    apb(1'b0, CCU_OFF_COUNT, 32'h00000000, rd, err);
    chk("result after reset", rd, 32'h00000000);
    chk("irq after reset", {31'h0, done_irq}, 32'h0);
    apb(1'b1, CCU_OFF_RELOAD, 32'h00001234, rd, err);
    apb(1'b0, CCU_OFF_RELOAD, 32'h00000000, rd, err);
    chk("reload readback", rd, 32'h00001234);
    apb(1'b1, CCU_OFF_COUNT, 32'h00FFFFFF, rd, err);
    apb(1'b0, CCU_OFF_COUNT, 32'h00000000, rd, err);
    chk("result is read only", rd, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000, rd, err);
    chk("unmapped error", {31'h0, err}, 32'h1);
    $display("test reset and map done");
  endtask : t_reset

  // Sub oscillator run with the interrupt masked: flag still set.
  task automatic t_sub();
    meas(1'b0, 1'b0, 16'h0008, 0);
    chk("done after sub run", {31'h0, last_ctrl[CCU_BIT_DONE]}, 32'h1);
    chk("sub result", in_range(res, 8, SUB_P), 32'h1);
    chk("irq masked", {31'h0, done_irq}, 32'h0);
    apb(1'b0, CCU_OFF_STATUS, 32'h00000000, rd, err);
    chk("status done", rd[0] ? 32'h1 : 32'h0, 32'h1);
    apb(1'b1, CCU_OFF_ENABLE, 32'h00000001, rd, err);
    // The enable lands at the edge that ends the write, so look once it has settled.
    @(negedge pclk);
    chk("irq enabled", {31'h0, done_irq}, 32'h1);
    apb(1'b1, CCU_OFF_CTRL, cw(1'b0, 1'b0, 1'b1, 1'b1), rd, err);
    apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
    chk("done kept on one", {31'h0, rd[CCU_BIT_DONE]}, 32'h1);
    apb(1'b1, CCU_OFF_CLEAR, 32'h00000001, rd, err);
    apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
    chk("done cleared", {31'h0, rd[CCU_BIT_DONE]}, 32'h0);
    chk("irq dropped", {31'h0, done_irq}, 32'h0);
    $display("test sub oscillator done");
  endtask : t_sub

  // RC oscillator with the interrupt on, then cleared through control.
  task automatic t_rc();
    meas(1'b1, 1'b1, 16'h0008, 0);
    chk("rc result", in_range(res, 8, RC_P), 32'h1);
    chk("irq on done", {31'h0, done_irq}, 32'h1);
    apb(1'b1, CCU_OFF_CTRL, cw(1'b0, 1'b1, 1'b0, 1'b1), rd, err);
    apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
    chk("done cleared by zero", {31'h0, rd[CCU_BIT_DONE]}, 32'h0);
    $display("test rc oscillator done");
  endtask : t_rc

  // Start rewritten mid-run must not restart the count.
  task automatic t_restart();
    meas(1'b0, 1'b0, 16'h0008, 200);
    chk("result after rewrite", in_range(res, 8, SUB_P), 32'h1);
    apb(1'b1, CCU_OFF_CLEAR, 32'h00000001, rd, err);
    $display("test restart ignored done");
  endtask : t_restart

  // Abort mid-run: no flag and the old result stays.
  task automatic t_abort();
    logic [31:0] old;
    apb(1'b0, CCU_OFF_COUNT, 32'h00000000, old, err);
    apb(1'b1, CCU_OFF_CTRL, cw(1'b1, 1'b0, 1'b0, 1'b1), rd, err);
    repeat (150) @(posedge pclk);
    apb(1'b1, CCU_OFF_CTRL, cw(1'b0, 1'b0, 1'b0, 1'b1), rd, err);
    apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
    chk("start after abort", {31'h0, rd[CCU_BIT_START]}, 32'h0);
    repeat (600) @(posedge pclk);
    apb(1'b0, CCU_OFF_CTRL, 32'h00000000, rd, err);
    chk("no done after abort", {31'h0, rd[CCU_BIT_DONE]}, 32'h0);
    chk("no irq after abort", {31'h0, done_irq}, 32'h0);
    apb(1'b0, CCU_OFF_COUNT, 32'h00000000, rd, err);
    chk("result kept", rd, old);
    $display("test abort done");
  endtask : t_abort

  // Main sequence; reset is held for five cycles first.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sub();
    t_rc();
    t_restart();
    t_abort();
    finish_test();
  end

endmodule : ccu_top_test
